// ### logic/nsq_defines.svh
// Offsets, field positions, command bytes and timing counts for the NAND sequencer.
// Assumes a 250 MHz system clock and byte-wide register port addressing.
`ifndef NSQ_DEFINES_SVH
`define NSQ_DEFINES_SVH

// Register byte offsets
`define NSQ_REG_CTRL 8'h00
`define NSQ_REG_WP 8'h04
`define NSQ_REG_ROW_A 8'h08
`define NSQ_REG_ROW_B 8'h0c
`define NSQ_REG_COL 8'h10
`define NSQ_REG_LEN 8'h14
`define NSQ_REG_DATA 8'h18
`define NSQ_REG_STAT 8'h1c

// Status register fields
`define NSQ_ST_BUSY 8
`define NSQ_ST_ERR 9
`define NSQ_ST_DREQ 10
`define NSQ_ST_MP_LO 11
`define NSQ_ST_RB 13

// Device command bytes
`define NSQ_C_READ 8'h00
`define NSQ_C_PROG 8'h80
`define NSQ_C_PROG2 8'h81
`define NSQ_C_COLCHG 8'h85
`define NSQ_C_CONFIRM 8'h10
`define NSQ_C_MPFIRST 8'h11
`define NSQ_C_CBREAD 8'h35
`define NSQ_C_ERASE 8'h60
`define NSQ_C_ERASE_GO 8'hd0
`define NSQ_C_STATUS 8'h70
`define NSQ_C_STATUS2 8'h71
`define NSQ_C_RESET 8'hff

// Limits and timing
`define NSQ_PROG_MAX 3'h4
`define NSQ_CLK_NS 4
`define NSQ_T_WB_NS 100
`define NSQ_WB_CYC ((`NSQ_T_WB_NS + `NSQ_CLK_NS - 1) / `NSQ_CLK_NS)
`define NSQ_DIV_DEF 4

`endif

// ### logic/nsq_pkg.sv
// Types shared by the NAND sequencer modules.
// Assumes nsq_defines.svh for all numeric constants.
package nsq_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PROG_LOAD = 4'h1, OP_COL_CHANGE = 4'h2, OP_CONFIRM = 4'h3,
    OP_CB_READ = 4'h4, OP_CB_LOAD = 4'h5, OP_MP_FIRST = 4'h6, OP_MP_SECOND = 4'h7,
    OP_MP_CONFIRM = 4'h8, OP_ERASE = 4'h9, OP_MERASE = 4'ha, OP_RESET = 4'hb,
    OP_STATUS = 4'hc
  } nsq_op_t;

  typedef enum logic [3:0] {
    K_END, K_CMD, K_ADDR5A, K_ADDR5B, K_ADDR3A, K_ADDR3B, K_COL2, K_DATA, K_WAIT, K_STAT
  } nsq_kind_t;

  typedef struct packed {
    nsq_kind_t kind;
    logic [7:0] val;
  } nsq_step_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_NEXT = 7'h02, S_WELO = 7'h04, S_WEHI = 7'h08,
    S_WAITD = 7'h10, S_BUSY = 7'h20, S_RDLO = 7'h40
  } nsq_state_t;

  // Pin outputs toward the flash; io_oe high while the bus is driven
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe;
  } nsq_pins_t;

endpackage

// ### logic/nsq_tick.sv
// Divider producing a one-cycle enable that paces the flash strobes.
// Assumes a single system clock; DIV cycles per pin phase.
`timescale 1ns/1ps
module nsq_tick #(
  parameter int DIV = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic tick_d;

  // A shorter phase would crowd the input synchroniser latency on status reads
  if (DIV < 4) begin : g_chk
    $error("nsq_tick: DIV must be at least 4");
  end

  // Count up and fire at the wrap
  always_comb begin
    tick_d = (cnt_q == W'(DIV - 1));
    cnt_d = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_tick <= tick_d;
    end
  end
endmodule // nsq_tick

// ### logic/nsq_sync.sv
// Three-stage synchroniser for pin inputs; a change counts once stages two and three agree.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module nsq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_d;

  // Stage one feeds only stage two
  always_comb begin
    out_d = o_sync;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      o_sync <= INIT;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_sync <= out_d;
    end
  end
endmodule // nsq_sync

// ### logic/nsq_ctrl.sv
// NAND program, erase and copy-back sequencer driving the flash pins.
// Assumes software sets rows, column and length before starting an operation.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "nsq_defines.svh"
module nsq_ctrl #(
  parameter int DIV = `NSQ_DIV_DEF,
  parameter int WB_CYC = `NSQ_WB_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_ready_busy_n,
  input wire logic [7:0] i_io,
  output nsq_pkg::nsq_pins_t o_pins
);
  if (WB_CYC < 1 || WB_CYC > 252) begin : g_chk
    $error("nsq_ctrl: WB_CYC out of range");
  end

  logic tick, rb_s;
  logic [7:0] io_s;
  nsq_tick #(.DIV(DIV)) u_tick (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_tick(tick));
  nsq_sync #(.W(1), .INIT(1'b1)) u_rb (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async(i_ready_busy_n), .o_sync(rb_s));
  nsq_sync #(.W(8), .INIT(8'h00)) u_io (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async(i_io), .o_sync(io_s));

  nsq_pkg::nsq_state_t st_q, st_d;
  nsq_pkg::nsq_op_t op_q, op_d;
  nsq_pkg::nsq_pins_t pins_d;
  nsq_pkg::nsq_step_t stp;
  logic [3:0] idx_q, idx_d;
  logic [2:0] sub_q, sub_d;
  logic [12:0] cnt_q, cnt_d, len_q, len_d, col_q, col_d;
  logic [16:0] row_a_q, row_a_d, row_b_q, row_b_d, prow_q, prow_d;
  logic [2:0] pcnt_q, pcnt_d;
  logic [7:0] wait_q, wait_d, data_q, data_d, stat_q, stat_d;
  logic [1:0] mp_q, mp_d;
  logic dval_q, dval_d, err_q, err_d, wp_q, wp_d;
  logic [31:0] rdata_d;
  logic start, refuse, consume, prog_op;
  nsq_pkg::nsq_op_t req;
  logic [16:0] prog_row;

  // Step list of each operation; index walks through it
  function automatic nsq_pkg::nsq_step_t step_of(nsq_pkg::nsq_op_t op, logic [3:0] i);
    nsq_pkg::nsq_kind_t k [9];
    logic [7:0] v [9];
    for (int j = 0; j < 9; j++) begin
      k[j] = nsq_pkg::K_END;
      v[j] = 8'h00;
    end
    case (op)
      nsq_pkg::OP_PROG_LOAD: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_PROG; k[1] = nsq_pkg::K_ADDR5A;
        k[2] = nsq_pkg::K_DATA;
      end
      nsq_pkg::OP_COL_CHANGE: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_COLCHG; k[1] = nsq_pkg::K_COL2;
        k[2] = nsq_pkg::K_DATA;
      end
      nsq_pkg::OP_CONFIRM: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_CONFIRM; k[1] = nsq_pkg::K_WAIT;
        k[2] = nsq_pkg::K_CMD; v[2] = `NSQ_C_STATUS; k[3] = nsq_pkg::K_STAT;
      end
      nsq_pkg::OP_CB_READ: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_READ; k[1] = nsq_pkg::K_ADDR5A;
        k[2] = nsq_pkg::K_CMD; v[2] = `NSQ_C_CBREAD; k[3] = nsq_pkg::K_WAIT;
      end
      nsq_pkg::OP_CB_LOAD: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_COLCHG; k[1] = nsq_pkg::K_ADDR5B;
        k[2] = nsq_pkg::K_DATA;
      end
      nsq_pkg::OP_MP_FIRST: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_PROG; k[1] = nsq_pkg::K_ADDR5A;
        k[2] = nsq_pkg::K_DATA; k[3] = nsq_pkg::K_CMD; v[3] = `NSQ_C_MPFIRST;
        k[4] = nsq_pkg::K_WAIT;
      end
      nsq_pkg::OP_MP_SECOND: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_PROG2; k[1] = nsq_pkg::K_ADDR5B;
        k[2] = nsq_pkg::K_DATA;
      end
      nsq_pkg::OP_MP_CONFIRM: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_CONFIRM; k[1] = nsq_pkg::K_WAIT;
        k[2] = nsq_pkg::K_CMD; v[2] = `NSQ_C_STATUS2; k[3] = nsq_pkg::K_STAT;
      end
      nsq_pkg::OP_ERASE: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_ERASE; k[1] = nsq_pkg::K_ADDR3A;
        k[2] = nsq_pkg::K_CMD; v[2] = `NSQ_C_ERASE_GO; k[3] = nsq_pkg::K_WAIT;
        k[4] = nsq_pkg::K_CMD; v[4] = `NSQ_C_STATUS; k[5] = nsq_pkg::K_STAT;
      end
      nsq_pkg::OP_MERASE: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_ERASE; k[1] = nsq_pkg::K_ADDR3A;
        k[2] = nsq_pkg::K_CMD; v[2] = `NSQ_C_ERASE; k[3] = nsq_pkg::K_ADDR3B;
        k[4] = nsq_pkg::K_CMD; v[4] = `NSQ_C_ERASE_GO; k[5] = nsq_pkg::K_WAIT;
        k[6] = nsq_pkg::K_CMD; v[6] = `NSQ_C_STATUS2; k[7] = nsq_pkg::K_STAT;
      end
      nsq_pkg::OP_RESET: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_RESET; k[1] = nsq_pkg::K_WAIT;
      end
      nsq_pkg::OP_STATUS: begin
        k[0] = nsq_pkg::K_CMD; v[0] = `NSQ_C_STATUS; k[1] = nsq_pkg::K_STAT;
      end
      default: begin
        k[0] = nsq_pkg::K_END;
      end
    endcase
    step_of.kind = (i < 4'd9) ? k[i] : nsq_pkg::K_END;
    step_of.val = (i < 4'd9) ? v[i] : 8'h00;
  endfunction

  // Address byte n of the five-cycle layout: two column bytes, three row bytes
  function automatic logic [7:0] addr_byte(logic [12:0] c, logic [16:0] r, logic [2:0] n);
    case (n)
      3'h0: addr_byte = c[7:0];
      3'h1: addr_byte = {3'h0, c[12:8]};
      3'h2: addr_byte = r[7:0];
      3'h3: addr_byte = r[15:8];
      default: addr_byte = {7'h00, r[16]};
    endcase
  endfunction

  // Even block is district 0, odd block district 1
  function automatic logic district(logic [16:0] r);
    district = r[6];
  endfunction

  assign stp = step_of(op_q, idx_q);
  assign req = nsq_pkg::nsq_op_t'(i_wdata[3:0]);
  assign start = i_wr && (i_addr == `NSQ_REG_CTRL) && (req != nsq_pkg::OP_NONE);
  assign prog_op = (req == nsq_pkg::OP_PROG_LOAD) || (req == nsq_pkg::OP_CB_LOAD) ||
                   (req == nsq_pkg::OP_MP_FIRST) || (req == nsq_pkg::OP_MP_SECOND);
  assign prog_row = ((req == nsq_pkg::OP_CB_LOAD) || (req == nsq_pkg::OP_MP_SECOND)) ?
                    row_b_q : row_a_q;
  assign consume = (st_q == nsq_pkg::S_WAITD) && dval_q && tick;

  // Acceptance checks on an operation request
  always_comb begin
    refuse = (st_q != nsq_pkg::S_IDLE);
    if (prog_op && (prog_row == prow_q) && (pcnt_q == `NSQ_PROG_MAX)) begin
      refuse = 1'b1;
    end
    case (mp_q)
      2'h1: if (req != nsq_pkg::OP_MP_SECOND && req != nsq_pkg::OP_STATUS &&
                req != nsq_pkg::OP_RESET) refuse = 1'b1;
      2'h2: if (req != nsq_pkg::OP_COL_CHANGE && req != nsq_pkg::OP_MP_CONFIRM &&
                req != nsq_pkg::OP_STATUS && req != nsq_pkg::OP_RESET) refuse = 1'b1;
      default: if (req == nsq_pkg::OP_MP_SECOND || req == nsq_pkg::OP_MP_CONFIRM)
                 refuse = 1'b1;
    endcase
    if (req == nsq_pkg::OP_MP_SECOND && ((district(row_a_q) == district(row_b_q)) ||
        (row_a_q[5:0] != row_b_q[5:0]))) begin
      refuse = 1'b1;
    end
    if (req == nsq_pkg::OP_MERASE && district(row_a_q) == district(row_b_q)) begin
      refuse = 1'b1;
    end
    if (req == nsq_pkg::OP_CB_LOAD && district(row_a_q) != district(row_b_q)) begin
      refuse = 1'b1;
    end
    if (req > nsq_pkg::OP_STATUS) begin
      refuse = 1'b1;
    end
  end

  // Register port, operation tracking and pin sequencing
  always_comb begin
    st_d = st_q; op_d = op_q; idx_d = idx_q; sub_d = sub_q; cnt_d = cnt_q;
    len_d = len_q; col_d = col_q; row_a_d = row_a_q; row_b_d = row_b_q;
    prow_d = prow_q; pcnt_d = pcnt_q; wait_d = wait_q; data_d = data_q;
    stat_d = stat_q; mp_d = mp_q; dval_d = dval_q; err_d = err_q; wp_d = wp_q;
    pins_d = o_pins;
    rdata_d = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        `NSQ_REG_WP: wp_d = i_wdata[0];
        `NSQ_REG_ROW_A: row_a_d = i_wdata[16:0];
        `NSQ_REG_ROW_B: row_b_d = i_wdata[16:0];
        `NSQ_REG_COL: col_d = i_wdata[12:0];
        `NSQ_REG_LEN: len_d = i_wdata[12:0];
        `NSQ_REG_STAT: if (i_wdata[`NSQ_ST_ERR]) err_d = 1'b0;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `NSQ_REG_CTRL: rdata_d = {28'h0, op_q};
        `NSQ_REG_WP: rdata_d = {31'h0, wp_q};
        `NSQ_REG_ROW_A: rdata_d = {15'h0, row_a_q};
        `NSQ_REG_ROW_B: rdata_d = {15'h0, row_b_q};
        `NSQ_REG_COL: rdata_d = {19'h0, col_q};
        `NSQ_REG_LEN: rdata_d = {19'h0, len_q};
        `NSQ_REG_STAT: rdata_d = {18'h0, rb_s, mp_q, (st_q == nsq_pkg::S_WAITD) && !dval_q,
                                  err_q, (st_q != nsq_pkg::S_IDLE), stat_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // A fresh data write beats the consume of the previous byte
    if (consume) dval_d = 1'b0;
    if (i_wr && i_addr == `NSQ_REG_DATA) begin
      dval_d = 1'b1;
      data_d = i_wdata[7:0];
    end
    if (start && refuse) err_d = 1'b1;
    if (start && !refuse) begin
      op_d = req; idx_d = 4'h0; sub_d = 3'h0; cnt_d = 13'h0000;
      st_d = nsq_pkg::S_NEXT;
      pins_d.ce_n = 1'b0;
      if (prog_op) begin
        prow_d = prog_row;
        pcnt_d = (prog_row == prow_q) ? pcnt_q + 3'h1 : 3'h1;
      end
      if ((req == nsq_pkg::OP_ERASE || req == nsq_pkg::OP_MERASE) &&
          (row_a_q[16:6] == prow_q[16:6] || row_b_q[16:6] == prow_q[16:6])) begin
        pcnt_d = 3'h0;
      end
      case (req)
        nsq_pkg::OP_MP_FIRST: mp_d = 2'h1;
        nsq_pkg::OP_MP_SECOND: mp_d = 2'h2;
        nsq_pkg::OP_MP_CONFIRM, nsq_pkg::OP_RESET: mp_d = 2'h0;
        default: ;
      endcase
    end
    // Write protect stays released while the page buffer is being filled from the array
    pins_d.wp_n = wp_d || ((op_d == nsq_pkg::OP_CB_READ) && (st_d != nsq_pkg::S_IDLE));
    case (st_q)
      nsq_pkg::S_IDLE: ;
      nsq_pkg::S_NEXT: begin
        pins_d.cle = 1'b0; pins_d.ale = 1'b0; pins_d.io_oe = 1'b0;
        case (stp.kind)
          nsq_pkg::K_END: begin
            st_d = nsq_pkg::S_IDLE;
            pins_d.ce_n = 1'b1;
          end
          nsq_pkg::K_CMD: if (tick) begin
            pins_d.cle = 1'b1; pins_d.io_out = stp.val; pins_d.io_oe = 1'b1;
            st_d = nsq_pkg::S_WELO;
          end
          nsq_pkg::K_DATA: begin
            if (len_q == 13'h0000) idx_d = idx_q + 4'h1;
            else st_d = nsq_pkg::S_WAITD;
          end
          nsq_pkg::K_WAIT: begin
            wait_d = 8'h00;
            st_d = nsq_pkg::S_BUSY;
          end
          nsq_pkg::K_STAT: if (tick) begin
            pins_d.re_n = 1'b0;
            st_d = nsq_pkg::S_RDLO;
          end
          default: if (tick) begin
            pins_d.ale = 1'b1; pins_d.io_oe = 1'b1;
            pins_d.io_out = addr_byte(col_q, (stp.kind == nsq_pkg::K_ADDR5B ||
              stp.kind == nsq_pkg::K_ADDR3B) ? row_b_q : row_a_q,
              (stp.kind == nsq_pkg::K_ADDR3A || stp.kind == nsq_pkg::K_ADDR3B) ?
              sub_q + 3'h2 : sub_q);
            st_d = nsq_pkg::S_WELO;
          end
        endcase
      end
      nsq_pkg::S_WAITD: if (consume) begin
        pins_d.io_out = data_q; pins_d.io_oe = 1'b1;
        st_d = nsq_pkg::S_WELO;
      end
      nsq_pkg::S_WELO: if (tick) begin
        pins_d.we_n = 1'b0;
        st_d = nsq_pkg::S_WEHI;
      end
      nsq_pkg::S_WEHI: if (tick) begin
        pins_d.we_n = 1'b1; // Rising edge latches the byte
        st_d = nsq_pkg::S_NEXT;
        case (stp.kind)
          nsq_pkg::K_CMD: idx_d = idx_q + 4'h1;
          nsq_pkg::K_DATA: begin
            if (cnt_q == len_q - 13'h0001) begin
              cnt_d = 13'h0000;
              idx_d = idx_q + 4'h1;
            end else begin
              cnt_d = cnt_q + 13'h0001;
              st_d = nsq_pkg::S_WAITD;
            end
          end
          default: begin
            if (sub_q == ((stp.kind == nsq_pkg::K_COL2) ? 3'h1 :
                (stp.kind == nsq_pkg::K_ADDR3A || stp.kind == nsq_pkg::K_ADDR3B) ?
                3'h2 : 3'h4)) begin
              sub_d = 3'h0;
              idx_d = idx_q + 4'h1;
            end else begin
              sub_d = sub_q + 3'h1;
            end
          end
        endcase
      end
      // Ready is ignored for the guard time plus three cycles; with the S_NEXT cycle that spans the four-cycle synchroniser delay
      nsq_pkg::S_BUSY: begin
        if (wait_q != 8'(WB_CYC + 3)) wait_d = wait_q + 8'h01;
        else if (rb_s) begin
          idx_d = idx_q + 4'h1;
          st_d = nsq_pkg::S_NEXT;
        end
      end
      // Strobe stays low two ticks: the synchronised bus lags the pin by four cycles
      nsq_pkg::S_RDLO: if (tick && sub_q == 3'h0) sub_d = 3'h1;
      else if (tick) begin
        sub_d = 3'h0;
        pins_d.re_n = 1'b1;
        stat_d = io_s;
        idx_d = idx_q + 4'h1;
        st_d = nsq_pkg::S_NEXT;
      end
      default: st_d = nsq_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= nsq_pkg::S_IDLE; op_q <= nsq_pkg::OP_NONE; idx_q <= 4'h0; sub_q <= 3'h0;
      cnt_q <= 13'h0000; len_q <= 13'h0000; col_q <= 13'h0000; row_a_q <= 17'h00000;
      row_b_q <= 17'h00000; prow_q <= 17'h1ffff; pcnt_q <= 3'h0; wait_q <= 8'h00;
      data_q <= 8'h00; stat_q <= 8'h00; mp_q <= 2'h0; dval_q <= 1'b0; err_q <= 1'b0;
      wp_q <= 1'b0; o_rdata <= 32'h0000_0000;
      o_pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0,
                  io_out: 8'h00, io_oe: 1'b0};
    end else begin
      st_q <= st_d; op_q <= op_d; idx_q <= idx_d; sub_q <= sub_d; cnt_q <= cnt_d;
      len_q <= len_d; col_q <= col_d; row_a_q <= row_a_d; row_b_q <= row_b_d;
      prow_q <= prow_d; pcnt_q <= pcnt_d; wait_q <= wait_d; data_q <= data_d;
      stat_q <= stat_d; mp_q <= mp_d; dval_q <= dval_d; err_q <= err_d; wp_q <= wp_d;
      o_rdata <= rdata_d; o_pins <= pins_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_wp_cbread: assert property (st_q != nsq_pkg::S_IDLE && op_q == nsq_pkg::OP_CB_READ
    |-> o_pins.wp_n) else $error("write protect low during buffer read");
  chk_prog_limit: assert property (start && prog_op && prog_row == prow_q &&
    pcnt_q == `NSQ_PROG_MAX |=> err_q && $stable(op_q)) else $error("fifth program taken");
  chk_confirm_wait: assert property (st_q == nsq_pkg::S_WEHI && tick && stp.kind ==
    nsq_pkg::K_CMD && stp.val == `NSQ_C_CONFIRM |=> ##[1:3] st_q == nsq_pkg::S_BUSY)
    else $error("no busy wait after confirm");
  chk_mp_gate: assert property (start && mp_q == 2'h1 && req == nsq_pkg::OP_ERASE &&
    st_q == nsq_pkg::S_IDLE
    |=> err_q && st_q == nsq_pkg::S_IDLE) else $error("command taken between planes");
  chk_mp_pair: assert property (start && req == nsq_pkg::OP_MP_SECOND &&
    row_a_q[5:0] != row_b_q[5:0] |=> mp_q == $past(mp_q))
    else $error("second plane page mismatch taken");
  chk_mp_exit: assert property ($fell(mp_q != 2'h0) |-> $past(op_d == nsq_pkg::OP_MP_CONFIRM ||
    op_d == nsq_pkg::OP_RESET)) else $error("multi program left without confirm");
  chk_merase_dist: assert property (start && req == nsq_pkg::OP_MERASE && st_q ==
    nsq_pkg::S_IDLE && district(row_a_q) == district(row_b_q) |=> st_q == nsq_pkg::S_IDLE)
    else $error("same district multi erase taken");
  chk_reset_clear: assert property (start && !refuse && req == nsq_pkg::OP_RESET |=> mp_q == 2'h0)
    else $error("reset left multi sequence pending");
  chk_cb_dist: assert property (start && req == nsq_pkg::OP_CB_LOAD &&
    district(row_a_q) != district(row_b_q) |=> err_q) else $error("cross district copy");
endmodule // nsq_ctrl

// ### test/nsq_flash_model.sv
// Behavioural flash device on the strobed pins: commands, addresses, busy and status.
// Assumes the bench resolves the shared I/O bus and may inject district failures.
`timescale 1ns/1ps
module nsq_flash_model #(
  parameter int BUSY_NS = 400
) (
  input wire nsq_pkg::nsq_pins_t i_pins,
  input wire logic [1:0] i_fail,
  output logic [7:0] o_io,
  output logic o_ready_busy_n
);
  logic [7:0] cmd_q = 8'h00;
  logic [12:0] col_q = 13'h0000;
  logic [1:0] touched = 2'h0;
  logic [2:0] fail_q = 3'h0; // Held until the next program or erase
  logic wp_cb = 1'b0;
  int acnt = 0;
  int nprog = 0;
  logic [7:0] stat;
  logic [2:0] sector;
  initial o_ready_busy_n = 1'b1;
  // Status byte; bus shows the inverse when not selected for output
  assign stat = {i_pins.wp_n, {2{o_ready_busy_n}}, 2'h0, fail_q};
  assign o_io = (!i_pins.ce_n && !i_pins.re_n && !i_pins.cle) ? stat : ~stat;
  // Correction sector of the current column: 512 main bytes paired with 16 spare bytes
  assign sector = (col_q >= 13'h1000) ? col_q[6:4] : col_q[11:9];
  // Bytes are latched on the write strobe rising edge
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && i_pins.cle) begin
      cmd_q = i_pins.io_out;
      acnt = 0;
      if (cmd_q == 8'h10 || cmd_q == 8'hd0) begin
        if (i_pins.wp_n) begin
          fail_q = {touched[1] & i_fail[1], touched[0] & i_fail[0], |(touched & i_fail)};
          nprog++;
          o_ready_busy_n = 1'b0;
          o_ready_busy_n <= #(BUSY_NS) 1'b1;
        end else begin
          fail_q = 3'h0; // Rejected while protected: nothing ran, nothing failed
        end
        touched = 2'h0;
      end else if (cmd_q == 8'h11 || cmd_q == 8'h35 || cmd_q == 8'hff) begin
        wp_cb = (cmd_q == 8'h35) ? i_pins.wp_n : wp_cb;
        touched = (cmd_q == 8'h11) ? touched : 2'h0;
        o_ready_busy_n = 1'b0;
        o_ready_busy_n <= #(BUSY_NS) 1'b1;
      end
    end else if (!i_pins.ce_n && i_pins.ale) begin
      if (acnt == 0) col_q[7:0] = i_pins.io_out;
      if (acnt == 1) col_q[12:8] = i_pins.io_out[4:0];
      if ((cmd_q == 8'h60) == (acnt == 0) && (acnt == 0 || acnt == 2))
        touched[i_pins.io_out[6]] = 1'b1;
      acnt++;
    end
  end
endmodule // nsq_flash_model

// ### test/tb_top.sv
// Self-checking bench for the sequencer: register tasks run whole flash operations.
// Assumes the flash model on the pins; design assertions run alongside.
`timescale 1ns/1ps
`include "nsq_defines.svh"
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic rb_n;
  logic [7:0] fl_io;
  logic [1:0] fail_sel = 2'h0;
  logic [31:0] st;
  nsq_pkg::nsq_pins_t pins;
  int failures = 0;
  int num_checks = 0;
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  nsq_ctrl #(.DIV(4), .WB_CYC(2)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ready_busy_n(rb_n),
    .i_io(pins.io_oe ? pins.io_out : fl_io), .o_pins(pins));
  nsq_flash_model i_flash (.i_pins(pins), .i_fail(fail_sel), .o_io(fl_io), .o_ready_busy_n(rb_n));
  // Register port accesses, one-cycle strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Start an op, feed data on request, wait until idle; bounded so a hang is reported
  task automatic run(input logic [3:0] op);
    logic [31:0] s;
    logic [7:0] b = 8'h5a;
    wr(`NSQ_REG_CTRL, {28'h0, op});
    @(posedge i_clk);
    for (int n = 0; n < 3000; n++) begin
      rd(`NSQ_REG_STAT, s);
      if (s[`NSQ_ST_DREQ]) begin
        wr(`NSQ_REG_DATA, {24'h0, b});
        b = b + 8'h01;
      end else if (!s[`NSQ_ST_BUSY]) return;
    end
    chk("op completion", 32'h0, 32'h1);
  endtask
  task automatic stat_is(input string n, input logic [7:0] e);
    rd(`NSQ_REG_STAT, st);
    chk(n, {24'h0, e}, {24'h0, st[7:0]});
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #150000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    chk("pins in reset", 32'h4c00, {17'h0, pins});
    i_rst_n <= 1'b1;
    wr(`NSQ_REG_WP, 32'h1);
    run(4'hc);
    stat_is("status ready", 8'he0);
    wr(`NSQ_REG_ROW_A, 32'h41);
    wr(`NSQ_REG_ROW_B, 32'h01);
    wr(`NSQ_REG_LEN, 32'h2);
    run(4'h1);
    wr(`NSQ_REG_COL, 32'h1010);
    wr(`NSQ_REG_LEN, 32'h1);
    run(4'h2);
    run(4'h3);
    chk("column change", 32'h1010, {19'h0, i_flash.col_q});
    chk("column sector", 32'h1, {29'h0, i_flash.sector});
    chk("one program", 32'h1, i_flash.nprog);
    stat_is("program status", 8'he0);
    $display("test single program done");
    fail_sel <= 2'h2;
    run(4'h6);
    run(4'h7);
    run(4'h8);
    stat_is("multi program 71h", 8'he5);
    wr(`NSQ_REG_ROW_B, 32'hc1);
    run(4'h6);
    run(4'h9);
    rd(`NSQ_REG_STAT, st);
    chk("erase between planes refused", 32'h1, {31'h0, st[`NSQ_ST_ERR]});
    wr(`NSQ_REG_STAT, 32'h200);
    run(4'h7);
    rd(`NSQ_REG_STAT, st);
    chk("same district refused", 32'h1, {31'h0, st[`NSQ_ST_ERR]});
    run(4'hb);
    wr(`NSQ_REG_STAT, 32'h200);
    wr(`NSQ_REG_ROW_B, 32'h01);
    run(4'ha);
    stat_is("multi erase 71h", 8'he5);
    $display("test multi plane done");
    wr(`NSQ_REG_WP, 32'h0);
    run(4'h9);
    stat_is("protected erase", 8'h60);
    run(4'h4);
    chk("wp high in copy read", 32'h1, {31'h0, i_flash.wp_cb});
    $display("test protect done");
    wr(`NSQ_REG_WP, 32'h1);
    fail_sel <= 2'h0;
    wr(`NSQ_REG_ROW_A, 32'h85);
    wr(`NSQ_REG_LEN, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`NSQ_REG_STAT, 32'h200);
      run(4'h1);
      run(4'h3);
      rd(`NSQ_REG_STAT, st);
      chk("program count", {31'h0, i == 4}, {31'h0, st[`NSQ_ST_ERR]});
    end
    $display("test program count done");
    wr(`NSQ_REG_STAT, 32'h200);
    run(4'ha);
    rd(`NSQ_REG_STAT, st);
    chk("same district erase refused", 32'h1, {31'h0, st[`NSQ_ST_ERR]});
    wr(`NSQ_REG_STAT, 32'h200);
    wr(`NSQ_REG_ROW_B, 32'hc1);
    run(4'h5);
    rd(`NSQ_REG_STAT, st);
    chk("cross district copy refused", 32'h1, {31'h0, st[`NSQ_ST_ERR]});
    $display("test district refusal done");
    report_and_stop();
  end
endmodule // tb_top
